//--- logic/flow_pulse_frequency_output.v
`include "pulse_freq_map.vh"
// Overview of operation
// R1: two modes, pulse and frequency, with pulse mode chosen after reset.
// R2: frequency mode gives a rate from zero to one kilohertz over the range.
// R3: frequency mode reaches one kilohertz when flow hits the upper range.
// R4: frequency mode gives zero hertz below the low-flow cutoff.
// R5: pulse mode gives one pulse per quantity 0.001 up to 100.0 units.
// R6: the counted unit is mass, volume or programmable, and picks the flow.
// R7: a programmable unit is scaled by its configured conversion factor.
// R8: unachievable pulse settings at upper-range flow raise an error.
// R9: a too-long pulse width is shortened and a saturation warning raised.
// R10: output rate is held to one over twice the width, and at most 1 kHz.
// R11: the attached counter is advised to use over 4 ms or 50 ms widths.
// R12: pulse mode keeps fractional remainders so no flow is lost.
module flow_pulse_frequency_output #(
	parameter W = 48,
	parameter FW = 16
) (
	input wire clk_sys,
	input wire rstn,
	input wire mode_freq_sel,
	input wire [1:0] count_unit_sel,
	input wire [2:0] pulse_qty_sel,
	input wire [15:0] pulse_width_ms,
	input wire [23:0] mass_flow_rate,
	input wire [23:0] volume_flow_rate,
	input wire [23:0] mass_flow_urv,
	input wire [23:0] volume_flow_urv,
	input wire [23:0] low_flow_cutoff,
	input wire [FW-1:0] unit_factor,
	input wire [FW-1:0] programmable_mass_count_unit,
	input wire [FW-1:0] programmable_volume_count_unit,
	output reg pulse_out_q,
	output reg mode_freq_q,
	output reg param_error_q,
	output reg saturated_q
);
	// flow words are in milli-units per second; unit_factor is 8.8 fixed
	localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
	localparam [W-1:0] ZERO = {W{1'b0}};
	localparam [W-1:0] ALL_ONES = {W{1'b1}};
	reg mode_q; // [R1]
	reg [23:0] flow_d;
	reg [23:0] urv_d;
	reg [FW-1:0] fac_d;
	reg [W-1:0] qty_d;
	reg [W+15:0] flow_prod_d;
	reg [W+15:0] urv_prod_d;
	reg [W-1:0] add_d;
	reg [W-1:0] urv_add_d;
	reg [W-1:0] clk_hz_d;
	reg [W-1:0] ms_cyc_d;
	reg [W-1:0] half_max_d;
	reg [W-1:0] step_d;
	reg [W-1:0] width_d;
	reg [W-1:0] rate_max_d;
	reg [W-1:0] width_lim_d;
	reg below_cut_d;
	reg [W-1:0] width_q;
	reg [W-1:0] hi_cnt_q;
	reg [W-1:0] lo_cnt_q;
	wire due;
	wire take;
	// mode register, pulse mode out of reset
	always @(posedge clk_sys) begin
		if (!rstn)
			mode_q <= `MODE_PULSE; // [R1]
		else
			mode_q <= mode_freq_sel;
	end
	// counted unit picks the flow, its range and its scale
	always @* begin
		flow_d = mass_flow_rate; // [R6]
		urv_d = mass_flow_urv;
		fac_d = unit_factor;
		case (count_unit_sel)
			`UNIT_MASS: begin
				fac_d = unit_factor;
			end
			`UNIT_VOLUME: begin
				flow_d = volume_flow_rate; // [R6]
				urv_d = volume_flow_urv;
			end
			`UNIT_PROG_MASS: begin
				fac_d = programmable_mass_count_unit; // [R7]
			end
			`UNIT_PROG_VOLUME: begin
				flow_d = volume_flow_rate;
				urv_d = volume_flow_urv;
				fac_d = programmable_volume_count_unit; // [R7]
			end
			default: begin
				fac_d = unit_factor;
			end
		endcase
	end
	// quantity in milli-units per pulse
	always @* begin
		qty_d = ZERO;
		case (pulse_qty_sel)
			3'h0: begin
				qty_d[16:0] = `QTY_0; // [R5]
			end
			3'h1: begin
				qty_d[16:0] = `QTY_1;
			end
			3'h2: begin
				qty_d[16:0] = `QTY_2;
			end
			3'h3: begin
				qty_d[16:0] = `QTY_3;
			end
			3'h4: begin
				qty_d[16:0] = `QTY_4;
			end
			default: begin
				qty_d[16:0] = `QTY_5;
			end
		endcase
	end
	// timing counts widened to the accumulator
	always @* begin
		clk_hz_d = ZERO;
		clk_hz_d[31:0] = `CLK_HZ;
		ms_cyc_d = ZERO;
		ms_cyc_d[31:0] = `CYC_PER_MS;
		half_max_d = ZERO;
		half_max_d[31:0] = `FREQ_MAX_HALF_CYC;
	end
	// scaled flow added per clock, and the same at upper range
	always @* begin
		flow_prod_d = {{(W-24){1'b0}}, flow_d} * {{(W-FW){1'b0}}, fac_d};
		urv_prod_d = {{(W-24){1'b0}}, urv_d} * {{(W-FW){1'b0}}, fac_d};
		urv_add_d = urv_prod_d[W+7:8];
		below_cut_d = (flow_d < low_flow_cutoff);
		add_d = flow_prod_d[W+7:8];
		if ((mode_q == `MODE_FREQ) && below_cut_d)
			add_d = ZERO; // [R4]
	end
	// accumulator threshold for one output pulse
	always @* begin
		if (mode_q == `MODE_FREQ) begin
			if (urv_add_d == ZERO)
				step_d = ALL_ONES;
			else
				step_d = urv_add_d * ms_cyc_d; // [R2] [R3]
		end else begin
			step_d = qty_d * clk_hz_d; // [R5]
		end
		if (step_d == ZERO)
			step_d = ONE;
	end
	// pulse width in clocks, capped by the upper-range rate
	always @* begin
		width_d = {{(W-16){1'b0}}, pulse_width_ms} * ms_cyc_d;
		if (mode_q == `MODE_FREQ)
			width_d = half_max_d;
		if (urv_add_d == ZERO)
			rate_max_d = ALL_ONES;
		else
			rate_max_d = (step_d / urv_add_d) >> 1;
		if (rate_max_d < width_d)
			width_lim_d = rate_max_d; // [R9]
		else
			width_lim_d = width_d;
		if (width_lim_d < half_max_d)
			width_lim_d = half_max_d; // [R10]
		if (width_lim_d == ZERO)
			width_lim_d = ONE;
	end
	assign take = due && !pulse_out_q && (lo_cnt_q == ZERO);
	phase_acc #(
		.W(W)
	) u_acc (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.clr(mode_q != mode_freq_sel),
		.add(add_d),
		.step(step_d),
		.take(take),
		.acc_q(),
		.due_q(due)
	); // [R12]
	// status flags; error and saturation flags in pulse mode only
	always @(posedge clk_sys) begin
		if (!rstn) begin
			mode_freq_q <= 1'b0;
			param_error_q <= 1'b0;
			saturated_q <= 1'b0;
			width_q <= ZERO;
		end else begin
			mode_freq_q <= mode_q;
			width_q <= width_lim_d;
			saturated_q <= (mode_q == `MODE_PULSE) &&
				(width_lim_d < width_d); // [R9]
			param_error_q <= (mode_q == `MODE_PULSE) &&
				(rate_max_d < half_max_d); // [R8]
		end
	end
	// pulse engine: high for width_q, then low for at least width_q
	always @(posedge clk_sys) begin
		if (!rstn) begin
			pulse_out_q <= 1'b0;
			hi_cnt_q <= ZERO;
			lo_cnt_q <= ZERO;
		end else begin
			if (pulse_out_q) begin
				if (hi_cnt_q <= ONE) begin
					pulse_out_q <= 1'b0;
					lo_cnt_q <= width_q; // [R10]
				end else begin
					hi_cnt_q <= hi_cnt_q - ONE;
				end
			end else if (lo_cnt_q != ZERO) begin
				lo_cnt_q <= lo_cnt_q - ONE;
			end else if (take) begin
				pulse_out_q <= 1'b1;
				hi_cnt_q <= width_q;
			end
		end
	end
endmodule // flow_pulse_frequency_output

//--- logic/pulse_freq_map.vh
`ifndef PULSE_FREQ_MAP_VH
`define PULSE_FREQ_MAP_VH
`define CLK_HZ 50000000
`define MODE_PULSE 1'b0
`define MODE_FREQ 1'b1
`define FREQ_MAX_HZ 1000
`define FREQ_MAX_HALF_CYC (`CLK_HZ / (2 * `FREQ_MAX_HZ))
`define CYC_PER_MS (`CLK_HZ / 1000)
`define UNIT_MASS 2'h0
`define UNIT_VOLUME 2'h1
`define UNIT_PROG_MASS 2'h2
`define UNIT_PROG_VOLUME 2'h3
`define QTY_MAX_SEL 3'h5
`define QTY_0 17'h00001
`define QTY_1 17'h0000A
`define QTY_2 17'h00064
`define QTY_3 17'h003E8
`define QTY_4 17'h02710
`define QTY_5 17'h186A0
`endif

//--- logic/phase_acc.v
module phase_acc #(
	parameter W = 40
) (
	input wire clk_sys,
	input wire rstn,
	input wire clr,
	input wire [W-1:0] add,
	input wire [W-1:0] step,
	input wire take,
	output reg [W-1:0] acc_q,
	output reg due_q
);
	reg [W:0] sum_d;
	reg [W-1:0] acc_d;
	always @* begin
		sum_d = {1'b0, acc_q} + {1'b0, add};
		if (take) begin
			if (sum_d >= {1'b0, step})
				sum_d = sum_d - {1'b0, step};
			else
				sum_d = {(W+1){1'b0}};
		end
		acc_d = sum_d[W-1:0];
		if (sum_d[W])
			acc_d = {W{1'b1}};
	end
	always @(posedge clk_sys) begin
		if (!rstn || clr) begin
			acc_q <= {W{1'b0}};
			due_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			due_q <= (acc_d >= step);
		end
	end
endmodule // phase_acc

//--- dv/pulse_counter.sv
module pulse_counter (
	input wire logic clk_sys,
	input wire logic pulse_in,
	output int n_pulses
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_q = 1'h0;
	// counts rising edges like an external counter
	always @(posedge clk_sys) begin
		last_q <= pulse_in;
		n_pulses <= n_pulses + int'(pulse_in & !last_q);
	end
endmodule // pulse_counter

//--- dv/fpo_checker.sv
module fpo_checker (
	input wire clk_sys,
	input wire rstn,
	input wire mode_freq_sel,
	input wire [15:0] pulse_width_ms,
	input wire [23:0] mass_flow_rate,
	input wire [23:0] low_flow_cutoff,
	input wire pulse_out_q,
	input wire mode_freq_q,
	input wire saturated_q
);
	timeunit 1ns;
	timeprecision 1ns;
	int hi_q, lo_q;
	wire [31:0] w = pulse_width_ms * 50000;
	wire fell = !pulse_out_q && hi_q != 0;
	wire rose = pulse_out_q && hi_q == 0;
	always @(posedge clk_sys) begin
		hi_q <= rstn && pulse_out_q ? hi_q + 1 : 0;
		lo_q <= !rstn || $changed(mode_freq_q) ? 1 << 24 :
			pulse_out_q ? 0 : lo_q + 1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	reset_clear_a: assert property ($rose(rstn) |-> !pulse_out_q)
		else $error("reset");
	mode_follow_a: assert property (rstn && $past(rstn) |=>
		mode_freq_q == $past(mode_freq_sel, 2)) else $error("mode");
	high_min_a: assert property (fell |-> hi_q >= 25000)
		else $error("high");
	low_min_a: assert property (rose |-> lo_q >= 25000)
		else $error("low");
	cutoff_quiet_a: assert property ((mode_freq_q &&
		mass_flow_rate < low_flow_cutoff)[*8] |=> !pulse_out_q)
		else $error("cutoff");
	pulse_cap_a: assert property (fell && !mode_freq_q |-> hi_q <= w)
		else $error("cap");
	pulse_exact_a: assert property (fell && !mode_freq_q &&
		!saturated_q |-> hi_q == w) else $error("width");
	pulse_gap_a: assert property (rose && !mode_freq_q &&
		!saturated_q |-> lo_q >= w) else $error("gap");
endmodule // fpo_checker
bind flow_pulse_frequency_output fpo_checker fpo_checker_inst (.*);

//--- dv/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'h0, rstn = 1'h0, mode_freq_sel = 1'h1;
	logic [1:0] count_unit_sel = 2'h0;
	logic [2:0] pulse_qty_sel = 3'h5;
	logic [15:0] pulse_width_ms = 16'h0005, unit_factor = 16'h0100;
	logic [15:0] programmable_mass_count_unit = 16'h0100;
	logic [15:0] programmable_volume_count_unit = 16'h0100;
	logic [23:0] mass_flow_rate = 24'h0F4240, mass_flow_urv = 24'h0F4240;
	logic [23:0] volume_flow_rate = 24'h000000, volume_flow_urv = 24'h0F4240;
	logic [23:0] low_flow_cutoff = 24'h0F4241;
	logic pulse_out_q, mode_freq_q, param_error_q, saturated_q;
	int n_errors, samples_checked, cycles, n_pulses;
	time a;
	flow_pulse_frequency_output flow_pulse_frequency_output_inst (.*);
	pulse_counter pulse_counter_inst (.clk_sys, .pulse_in(pulse_out_q),
		.n_pulses);
	initial forever #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (++cycles == 95000) begin
		n_errors++;
		finish_test();
	end
	task chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task lvl(input logic v);
		for (int k = 0; k < 60000 && pulse_out_q !== v; k++) @(negedge clk_sys);
		chk(pulse_out_q, v);
	endtask
	task flags(input logic [1:0] e);
		for (int k = 0; k < 16 && {param_error_q, saturated_q} !== e; k++)
			@(negedge clk_sys);
		chk({param_error_q, saturated_q}, e);
	endtask
	task t_freq;
		repeat (2000) @(negedge clk_sys);
		chk(n_pulses, 0);
		low_flow_cutoff = 24'h0003E8;
		lvl(1'h1);
		a = $time;
		lvl(1'h0);
		chk(32'(($time - a + 100) / 200), 2500);
		chk(n_pulses, 1);
	endtask
	task t_flags;
		mode_freq_sel = 1'h0;
		mass_flow_urv = 24'h1E8480;
		mass_flow_rate = 24'h1E8480;
		pulse_qty_sel = 3'h0;
		flags(2'h3);
		pulse_qty_sel = 3'h5;
		flags(2'h0);
	endtask
	task finish_test;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk_sys);
		rstn = 1'h1;
		chk(mode_freq_q, 0);
		t_freq();
		t_flags();
		finish_test();
	end
endmodule // tb
